// [rtl/pgd_regs.svh]
`ifndef PGD_REGS_SVH
`define PGD_REGS_SVH
`define PGD_CTRL_OFS 8'h60
`define PGD_STAT_OFS 8'h61
`define PGD_LEN_OFS 8'h62
`define PGD_TAP_OFS 8'h63
`define PGD_ERRINS_OFS 8'h64
`define PGD_PAT0_OFS 8'h68
`define PGD_PAT1_OFS 8'h69
`define PGD_PAT2_OFS 8'h6a
`define PGD_PAT3_OFS 8'h6b
`define PGD_RES0_OFS 8'h6c
`define PGD_RES1_OFS 8'h6d
`define PGD_RES2_OFS 8'h6e
`define PGD_RES3_OFS 8'h6f
`define PGD_CTRL_RST 8'h02
`define PGD_PAT_RST 32'h0000_0000
`define PGD_CTRL_FN_HI 7
`define PGD_CTRL_FN_LO 6
`define PGD_CTRL_PTYPE 4
`define PGD_CTRL_TINV 3
`define PGD_CTRL_RINV 2
`define PGD_CTRL_AUTO 1
`define PGD_CTRL_MAN 0
`define PGD_ERRINS_EVENT 3
`define PGD_STAT_SYNC 4
`define PGD_STAT_SYNCI 3
`define PGD_STAT_BEI 2
`define PGD_STAT_XFERI 1
`define PGD_STAT_OVR 0
`define PGD_SYNC_GOOD_BITS 6'd48
`define PGD_WIN_BITS 6'd48
`define PGD_LOSS_ERRS 4'd10
`define PGD_RATE_MIN 3'h2
`define PGD_RATE_P2 24'd100
`define PGD_RATE_P3 24'd1000
`define PGD_RATE_P4 24'd10000
`define PGD_RATE_P5 24'd100000
`define PGD_RATE_P6 24'd1000000
`define PGD_RATE_P7 24'd10000000
`endif

// [rtl/pgd_pkg.sv]
package pgd_pkg;
    typedef enum logic [1:0] {PGD_FN_PAT0, PGD_FN_PAT1, PGD_FN_ERR, PGD_FN_BIT} pgd_func_t;
    typedef enum logic {PGD_HUNT, PGD_LOCK} pgd_sync_t;
endpackage : pgd_pkg

// [rtl/pgd_top.sv]
`timescale 1ns/10ps
`include "pgd_regs.svh"
module pgd_top (
    // Clock, reset and freeze.
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ce,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // Global events.
    input wire logic perf_monitor_wr,
    input wire logic one_sec_tick,
    // Bit streams.
    input wire logic bit_strobe,
    output logic tx_bit,
    input wire logic rx_bit,
    output logic pattern_in_sync
);
    import pgd_pkg::*;

    pgd_func_t fn_sel_r;
    pgd_sync_t sync_st_r;
    logic ps_r, tinv_r, rinv_r, auto_r, man_r, evt_r;
    logic [4:0] len_field_r, tap_field_r;
    logic [2:0] rate_code_r;
    logic [31:0] pat_r, gen_r, rx_sh_r, err_cnt_r, bit_cnt_r, result_r;
    logic act_ps_r, single_pend_r, hunt_en_r, in_sync_r;
    logic [5:0] act_len_r, act_tap_r, good_cnt_r, win_cnt_r;
    logic [3:0] win_err_r;
    logic [23:0] rate_cnt_r;
    logic synci_r, bei_r, xferi_r, ovr_r, tx_bit_r;
    logic [7:0] rdata_r;
    localparam logic [7:0] ctrl_rst_val = `PGD_CTRL_RST;

    function automatic logic hit(input logic [7:0] a);
        return reg_wr && reg_addr == a;
    endfunction : hit

    // Bit of a history register at one-based position p.
    function automatic logic pick(input logic [31:0] v, input logic [5:0] p);
        return v[5'(p - 6'd1)];
    endfunction : pick

    function automatic logic [23:0] rate_period(input logic [2:0] c);
        unique case (c)
            3'h2: return `PGD_RATE_P2;
            3'h3: return `PGD_RATE_P3;
            3'h4: return `PGD_RATE_P4;
            3'h5: return `PGD_RATE_P5;
            3'h6: return `PGD_RATE_P6;
            3'h7: return `PGD_RATE_P7;
            default: return 24'h0;
        endcase
    endfunction : rate_period

    logic step, gen_out, gen_fb, rate_hit, rx_in, rx_exp, rx_err;
    logic res_wr, refresh, man_rise, evt_rise, lose, gain;
    assign step = ce && bit_strobe;
    assign gen_out = pick(gen_r, act_len_r);
    assign gen_fb = act_ps_r ? gen_out : gen_out ^ pick(gen_r, act_tap_r);
    assign rate_hit = rate_code_r >= `PGD_RATE_MIN
        && rate_cnt_r == rate_period(rate_code_r) - 24'd1;
    assign rx_in = rx_bit ^ rinv_r;
    assign rx_exp = act_ps_r ? pick(rx_sh_r, act_len_r)
        : pick(rx_sh_r, act_len_r) ^ pick(rx_sh_r, act_tap_r);
    assign rx_err = rx_in != rx_exp;
    assign res_wr = reg_wr && reg_addr >= `PGD_RES0_OFS && reg_addr <= `PGD_RES3_OFS;
    assign refresh = one_sec_tick || perf_monitor_wr || res_wr;
    assign man_rise = hit(`PGD_CTRL_OFS) && reg_wdata[`PGD_CTRL_MAN] && !man_r;
    assign evt_rise = hit(`PGD_ERRINS_OFS) && reg_wdata[`PGD_ERRINS_EVENT] && !evt_r;
    assign lose = sync_st_r == PGD_LOCK && win_err_r + 4'(rx_err) >= `PGD_LOSS_ERRS;
    assign gain = sync_st_r == PGD_HUNT && hunt_en_r && !rx_err
        && good_cnt_r + 6'd1 == `PGD_SYNC_GOOD_BITS;

    // Software control registers.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            fn_sel_r <= pgd_func_t'(ctrl_rst_val[`PGD_CTRL_FN_HI:`PGD_CTRL_FN_LO]);
            {ps_r, tinv_r, rinv_r, auto_r, man_r} <= ctrl_rst_val[`PGD_CTRL_PTYPE:`PGD_CTRL_MAN];
            len_field_r <= 5'h0;
            tap_field_r <= 5'h0;
            evt_r <= 1'b0;
            rate_code_r <= 3'h0;
            pat_r <= `PGD_PAT_RST;
        end else if (ce) begin
            if (hit(`PGD_CTRL_OFS)) begin
                fn_sel_r <= pgd_func_t'(reg_wdata[`PGD_CTRL_FN_HI:`PGD_CTRL_FN_LO]);
                {ps_r, tinv_r, rinv_r, auto_r, man_r} <= reg_wdata[`PGD_CTRL_PTYPE:`PGD_CTRL_MAN];
            end
            if (hit(`PGD_LEN_OFS)) begin
                len_field_r <= reg_wdata[4:0];
            end
            if (hit(`PGD_TAP_OFS)) begin
                tap_field_r <= reg_wdata[4:0];
            end
            if (hit(`PGD_ERRINS_OFS)) begin
                evt_r <= reg_wdata[`PGD_ERRINS_EVENT];
                rate_code_r <= reg_wdata[2:0];
            end
            for (int i = 0; i < 4; i++) begin
                if (hit(`PGD_PAT0_OFS + 8'(i))) begin
                    pat_r[8*i +: 8] <= reg_wdata;
                end
            end
        end
    end

    // Generator: the top pattern byte write loads the live configuration and seed.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            act_ps_r <= 1'b0;
            act_len_r <= 6'd1;
            act_tap_r <= 6'd1;
            gen_r <= `PGD_PAT_RST;
        end else if (ce) begin
            if (hit(`PGD_PAT3_OFS)) begin
                act_ps_r <= ps_r;
                act_len_r <= {1'b0, len_field_r} + 6'd1;
                act_tap_r <= {1'b0, tap_field_r} + 6'd1;
                gen_r <= {reg_wdata, pat_r[23:0]};
            end else if (bit_strobe) begin
                gen_r <= {gen_r[30:0], gen_fb};
            end
        end
    end

    // Error insertion and transmit bit.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            single_pend_r <= 1'b0;
            rate_cnt_r <= 24'h0;
            tx_bit_r <= 1'b0;
        end else if (ce) begin
            single_pend_r <= evt_rise || single_pend_r && !bit_strobe;
            rate_cnt_r <= rate_code_r < `PGD_RATE_MIN || rate_hit && bit_strobe ? 24'h0
                : rate_cnt_r + 24'(bit_strobe);
            if (bit_strobe) begin
                tx_bit_r <= gen_out ^ tinv_r ^ (single_pend_r || rate_hit);
            end
        end
    end

    // Receive history and sync search.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_sh_r <= 32'h0;
            sync_st_r <= PGD_HUNT;
            in_sync_r <= 1'b0;
            hunt_en_r <= 1'b1;
            good_cnt_r <= 6'h0;
            win_cnt_r <= 6'h0;
            win_err_r <= 4'h0;
        end else if (ce) begin
            if (bit_strobe) begin
                rx_sh_r <= {rx_sh_r[30:0], rx_in};
            end
            if (man_rise) begin
                sync_st_r <= PGD_HUNT;
                in_sync_r <= 1'b0;
                hunt_en_r <= 1'b1;
                good_cnt_r <= 6'h0;
            end else if (bit_strobe) begin
                unique case (sync_st_r)
                    PGD_HUNT: begin
                        good_cnt_r <= rx_err || !hunt_en_r ? 6'h0 : good_cnt_r + 6'd1;
                        if (gain) begin
                            sync_st_r <= PGD_LOCK;
                            in_sync_r <= 1'b1;
                            win_cnt_r <= 6'h0;
                            win_err_r <= 4'h0;
                        end
                    end
                    PGD_LOCK: begin
                        if (lose) begin
                            sync_st_r <= PGD_HUNT;
                            in_sync_r <= 1'b0;
                            hunt_en_r <= auto_r;
                            good_cnt_r <= 6'h0;
                        end else if (win_cnt_r == `PGD_WIN_BITS - 6'd1) begin
                            win_cnt_r <= 6'h0;
                            win_err_r <= 4'h0;
                        end else begin
                            win_cnt_r <= win_cnt_r + 6'd1;
                            win_err_r <= win_err_r + 4'(rx_err);
                        end
                    end
                endcase
            end
        end
    end

    // Counters restart from the current bit whenever the result is refreshed.
    logic err_inc, bit_inc;
    assign err_inc = step && rx_err && sync_st_r == PGD_LOCK;
    assign bit_inc = step;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            err_cnt_r <= 32'h0;
            bit_cnt_r <= 32'h0;
            result_r <= 32'h0;
        end else if (ce) begin
            if (refresh) begin
                err_cnt_r <= 32'(err_inc);
                bit_cnt_r <= 32'(bit_inc);
                unique case (fn_sel_r)
                    PGD_FN_PAT0, PGD_FN_PAT1: result_r <= rx_sh_r;
                    PGD_FN_ERR: result_r <= err_cnt_r;
                    PGD_FN_BIT: result_r <= bit_cnt_r;
                endcase
            end else begin
                err_cnt_r <= err_cnt_r + 32'(err_inc);
                bit_cnt_r <= bit_cnt_r + 32'(bit_inc);
            end
        end
    end

    // Sticky status, cleared by reading; a new event in the read cycle wins, except for the overrun bit.
    logic stat_rd;
    assign stat_rd = reg_rd && reg_addr == `PGD_STAT_OFS;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            {synci_r, bei_r, xferi_r, ovr_r} <= 4'h0;
        end else if (ce) begin
            synci_r <= step && !man_rise && (gain || lose) || man_rise && in_sync_r
                || synci_r && !stat_rd;
            bei_r <= err_inc || bei_r && !stat_rd;
            xferi_r <= refresh || xferi_r && !stat_rd;
            ovr_r <= refresh && xferi_r && !stat_rd || ovr_r && !stat_rd;
        end
    end

    // Read port; result bytes ignore writes apart from the refresh.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= 8'h0;
        end else if (ce && reg_rd) begin
            unique case (reg_addr)
                `PGD_CTRL_OFS: rdata_r <= {fn_sel_r, 1'b0, ps_r, tinv_r, rinv_r, auto_r, man_r};
                `PGD_STAT_OFS: rdata_r <= {3'h0, in_sync_r, synci_r, bei_r, xferi_r, ovr_r};
                `PGD_LEN_OFS: rdata_r <= {3'h0, len_field_r};
                `PGD_TAP_OFS: rdata_r <= {3'h0, tap_field_r};
                `PGD_ERRINS_OFS: rdata_r <= {4'h0, evt_r, rate_code_r};
                `PGD_PAT0_OFS, `PGD_PAT1_OFS, `PGD_PAT2_OFS, `PGD_PAT3_OFS:
                    rdata_r <= pat_r[{reg_addr[1:0], 3'h0} +: 8];
                `PGD_RES0_OFS, `PGD_RES1_OFS, `PGD_RES2_OFS, `PGD_RES3_OFS:
                    rdata_r <= result_r[{reg_addr[1:0], 3'h0} +: 8];
                default: rdata_r <= 8'h0;
            endcase
        end
    end

    assign reg_rdata = rdata_r;
    assign tx_bit = tx_bit_r;
    assign pattern_in_sync = in_sync_r;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_single_err;
        ce && evt_rise |=> single_pend_r;
    endproperty
    a_single_err: assert property (p_single_err) else $error("event edge lost");
    property p_rate_off;
        rate_code_r < `PGD_RATE_MIN |-> !rate_hit;
    endproperty
    a_rate_off: assert property (p_rate_off) else $error("error at zero rate");
    property p_apply;
        ce && reg_wr && reg_addr == `PGD_PAT3_OFS
            |=> gen_r == {$past(reg_wdata), $past(pat_r[23:0])}
            && act_len_r == $past(len_field_r) + 6'd1 && act_tap_r == $past(tap_field_r) + 6'd1;
    endproperty
    a_apply: assert property (p_apply) else $error("config not applied");
    property p_tx_clean;
        step && !single_pend_r && !rate_hit |=> tx_bit_r == $past(gen_out ^ tinv_r);
    endproperty
    a_tx_clean: assert property (p_tx_clean) else $error("tx bit wrong");
    property p_rep_rot;
        step && act_ps_r && !(reg_wr && reg_addr == `PGD_PAT3_OFS) |=> gen_r[0] == $past(gen_out);
    endproperty
    a_rep_rot: assert property (p_rep_rot) else $error("repeat broken");
    property p_prbs_fb;
        step && !act_ps_r && !(reg_wr && reg_addr == `PGD_PAT3_OFS)
            |=> gen_r[0] == $past(gen_out ^ pick(gen_r, act_tap_r));
    endproperty
    a_prbs_fb: assert property (p_prbs_fb) else $error("feedback wrong");
    property p_err_hold;
        ce && sync_st_r == PGD_HUNT && !refresh |=> err_cnt_r == $past(err_cnt_r);
    endproperty
    a_err_hold: assert property (p_err_hold) else $error("counted out of sync");
    property p_bit_cnt;
        step && !refresh |=> bit_cnt_r == $past(bit_cnt_r) + 32'd1;
    endproperty
    a_bit_cnt: assert property (p_bit_cnt) else $error("bit count wrong");
    property p_res_err;
        ce && refresh && fn_sel_r == PGD_FN_ERR |=> result_r == $past(err_cnt_r);
    endproperty
    a_res_err: assert property (p_res_err) else $error("error result wrong");
    property p_res_pat;
        ce && res_wr && fn_sel_r == PGD_FN_PAT1 |=> result_r == $past(rx_sh_r);
    endproperty
    a_res_pat: assert property (p_res_pat) else $error("pattern result wrong");
    property p_gain;
        step && !man_rise && gain |=> in_sync_r ##1 !ce || in_sync_r || lose;
    endproperty
    a_gain: assert property (p_gain) else $error("sync not declared");
    c_lock: cover property (step && gain);
    c_lose: cover property (step && lose);
    c_rate: cover property (step && rate_hit);
    c_tick: cover property (ce && one_sec_tick && fn_sel_r == PGD_FN_BIT);
endmodule : pgd_top

// [tb/pgd_framer_model.sv]
`timescale 1ns/10ps
module pgd_framer_model (
    // Clock and reset.
    input wire logic mclk,
    input wire logic rst_n,
    // Bit streams.
    input wire logic tx_bit,
    output logic bit_strobe,
    output logic rx_bit
);
    logic noisy = 1'b0;
    logic rnd = 1'b0;
    int n_pos = 0;
    int n_neg = 0;
    logic rxq[$];
    logic txq[$];
    // Between strobes the clean line shows the inverse, so a stale bit is never taken; when noisy the line shows random bits.
    assign rx_bit = noisy ? rnd : (bit_strobe ? tx_bit : ~tx_bit);
    initial bit_strobe = 1'b0;
    always @(posedge mclk) begin
        if (bit_strobe && rst_n) begin
            rxq.push_back(rx_bit);
            n_pos++;
        end
    end
    always @(negedge mclk) begin
        if (n_neg != n_pos) begin
            txq.push_back(tx_bit);
            n_neg = n_pos;
        end
    end
    task automatic send_bits(input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            @(posedge mclk);
            bit_strobe <= 1'b1;
            rnd <= 1'($urandom);
            if (gap > 0) begin
                @(posedge mclk);
                bit_strobe <= 1'b0;
                repeat (gap - 1) @(posedge mclk);
            end
        end
        @(posedge mclk);
        bit_strobe <= 1'b0;
        @(posedge mclk);
    endtask : send_bits
endmodule : pgd_framer_model

// [tb/pgd_top_tb.sv]
`timescale 1ns/10ps
module pgd_top_tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic perf_monitor_wr = 1'b0;
    logic one_sec_tick = 1'b0;
    logic bit_strobe;
    logic tx_bit;
    logic rx_bit;
    logic pattern_in_sync;
    int n_errors = 0;
    int samples_checked = 0;
    int s;
    int s0;
    logic [31:0] pat;
    logic [31:0] v;
    logic [7:0] b;

    pgd_top uut (.mclk(mclk), .rst_n(rst_n), .ce(ce), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .perf_monitor_wr(perf_monitor_wr), .one_sec_tick(one_sec_tick),
        .bit_strobe(bit_strobe), .tx_bit(tx_bit), .rx_bit(rx_bit),
        .pattern_in_sync(pattern_in_sync));
    pgd_framer_model p (.mclk(mclk), .rst_n(rst_n), .tx_bit(tx_bit), .bit_strobe(bit_strobe),
        .rx_bit(rx_bit));

    initial begin
        forever #12.5 mclk = ~mclk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        d = reg_rdata;
    endtask : rd

    task automatic rd32(input logic [7:0] a, output logic [31:0] d);
        logic [7:0] t;
        for (int i = 0; i < 4; i++) begin
            rd(a + 8'(i), t);
            d[8*i +: 8] = t;
        end
    endtask : rd32

    task automatic pulse(input bit tick);
        @(posedge mclk);
        if (tick) one_sec_tick <= 1'b1;
        else perf_monitor_wr <= 1'b1;
        @(posedge mclk);
        one_sec_tick <= 1'b0;
        perf_monitor_wr <= 1'b0;
    endtask : pulse

    // Received history as the result shows it: newest bit in bit 0.
    function automatic logic [31:0] hist();
        logic [31:0] h;
        for (int i = 0; i < 32; i++) h[i] = p.rxq[p.rxq.size() - 1 - i];
        return h;
    endfunction : hist

    function automatic int errs(input int st, input int len);
        int n = 0;
        for (int i = st; i < p.rxq.size(); i++) if (p.rxq[i] !== p.rxq[i - len]) n++;
        return n;
    endfunction : errs

    function automatic int txerr(input int st, input int len, input logic [31:0] pv);
        int n = 0;
        for (int i = st; i < p.txq.size(); i++) if (p.txq[i] !== pv[len - 1 - (i - st) % len]) n++;
        return n;
    endfunction : txerr

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (30000) @(posedge mclk);
        n_errors++;
        give_verdict();
    end

    initial begin
        void'($urandom(32'h6773c248));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            rd(8'h68 + 8'(i), b);
            check("pattern byte reset", 32'(b), 32'h0);
        end
        rd(8'h60, b);
        check("ctrl reset", 32'(b), 32'h02);
        $display("reset values done");

        pat = $urandom;
        wr(8'h60, 8'h52);
        wr(8'h62, 8'h07);
        for (int i = 0; i < 3; i++) wr(8'h68 + 8'(i), pat[8*i +: 8]);
        s0 = p.txq.size();
        wr(8'h6b, pat[31:24]);
        rd32(8'h68, v);
        check("pattern readback", v, pat);
        p.send_bits(80, 0);
        check("repetitive tx", 32'(txerr(s0, 8, pat)), 32'h0);
        check("sync gained", 32'(pattern_in_sync), 32'h1);
        wr(8'h6c, 8'hff);
        rd32(8'h6c, v);
        check("received pattern", v, hist());
        @(posedge mclk);
        ce <= 1'b0;
        wr(8'h62, 8'h1f);
        ce <= 1'b1;
        rd(8'h62, b);
        check("frozen write", 32'(b), 32'h07);
        $display("repetitive pattern done");

        wr(8'h60, 8'hd2);
        pulse(1'b0);
        p.send_bits(300, 1);
        pulse(1'b1);
        rd32(8'h6c, v);
        check("bit count", v, 32'd300);
        wr(8'h6e, 8'hff);
        rd32(8'h6c, v);
        check("result after write", v, 32'h0);
        $display("bit count done");

        wr(8'h60, 8'h92);
        s = p.rxq.size();
        wr(8'h6d, 8'h00);
        wr(8'h64, 8'h08);
        wr(8'h64, 8'h08);
        p.send_bits(60, 0);
        wr(8'h64, 8'h00);
        wr(8'h64, 8'h08);
        p.send_bits(60, 0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h64, 8'h00);
            wr(8'h64, 8'(c));
            p.send_bits(1050, 0);
        end
        check("inserted errors", 32'(txerr(s0, 8, pat)), 32'd13);
        check("sync kept", 32'(pattern_in_sync), 32'h1);
        wr(8'h6c, 8'h00);
        rd32(8'h6c, v);
        check("error count", v, 32'(errs(s, 8)));
        $display("error insertion done");

        @(posedge mclk);
        p.noisy <= 1'b1;
        p.send_bits(96, 0);
        check("sync lost", 32'(pattern_in_sync), 32'h0);
        pulse(1'b0);
        p.send_bits(200, 0);
        pulse(1'b0);
        rd32(8'h6c, v);
        check("no count out of sync", v, 32'h0);
        @(posedge mclk);
        p.noisy <= 1'b0;
        $display("out of sync done");

        wr(8'h64, 8'h00);
        wr(8'h60, 8'h02);
        wr(8'h62, 8'h06);
        wr(8'h63, 8'h05);
        for (int i = 0; i < 3; i++) wr(8'h68 + 8'(i), 8'hff);
        s0 = p.txq.size();
        wr(8'h6b, 8'hff);
        p.send_bits(100, 0);
        s = 0;
        for (int i = 0; i < 7; i++) if (p.txq[s0 + i] !== 1'b1) s++;
        check("seed bits", 32'(s), 32'h0);
        s = 0;
        for (int i = s0 + 7; i < p.txq.size(); i++)
            if (p.txq[i] !== (p.txq[i - 7] ^ p.txq[i - 6])) s++;
        check("feedback sequence", 32'(s), 32'h0);
        check("prbs sync", 32'(pattern_in_sync), 32'h1);
        $display("pseudo-random done");
        give_verdict();
    end
endmodule : pgd_top_tb
